/* include/sgc_pkg.sv */
// shared constants and types for the switch global control bank
package sgc_pkg;
  localparam logic [7:0] SGC_ADDR_ID0   = 8'h00;
  localparam logic [7:0] SGC_ADDR_ID1   = 8'h01;
  localparam logic [7:0] SGC_ADDR_CTL0  = 8'h02;
  localparam logic [7:0] SGC_ADDR_CTL1  = 8'h03;
  // identity values are arbitrary
  localparam logic [7:0] SGC_FAMILY_ID  = 8'h5a;
  localparam logic [3:0] SGC_CHIP_ID    = 4'h3;
  localparam logic [2:0] SGC_REV_ID     = 3'h1;
  localparam logic [7:0] SGC_CTL0_RST   = 8'h44;
  localparam logic [7:0] SGC_CTL0_WMASK = 8'h8f;
  localparam logic [7:0] SGC_CTL1_RST   = 8'h30;
  localparam int         SGC_B_START    = 0;
  localparam int         SGC_B_BACKOFF  = 7;
  localparam int         SGC_B_PASSFC   = 3;
  localparam int         SGC_B_LINKAGE  = 0;
  localparam int         SGC_B_PASSALL  = 7;
  localparam int         SGC_B_TXFC     = 5;
  localparam int         SGC_B_RXFC     = 4;
  localparam int         SGC_B_LENCHK   = 3;
  localparam logic [1:0] SGC_PS_AUTO    = 2'h0;
  localparam logic [15:0] SGC_LEN_LIMIT = 16'h05dc;
  localparam int         SGC_FAST_AGE_US = 800;
  localparam int         SGC_CLK_MHZ    = 250;
  localparam int         SGC_FAST_AGE_CYC = SGC_FAST_AGE_US * SGC_CLK_MHZ - 1;
  localparam int         SGC_ROM_WAIT   = 16;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sgc_req_t;

  typedef struct packed {
    logic backoff_alt;
    logic pass_fc;
    logic link_age;
    logic pass_all;
    logic tx_pause;
    logic rx_pause;
    logic len_check;
  } sgc_cfg_t;

  typedef enum logic [2:0] {
    SGC_ST_IDLE  = 3'b000,
    SGC_ST_ROMRD = 3'b001,
    SGC_ST_CHECK = 3'b010,
    SGC_ST_LOAD  = 3'b011,
    SGC_ST_HOLD  = 3'b100,
    SGC_ST_RUN   = 3'b101
  } sgc_state_t;
endpackage

/* logic/sgc_bank.sv */
// global control register bank and start-up sequencer
`timescale 1ns/10ps
// What this block does
// - non-auto strap modes run only while start bit is one; resets one
// - auto strap mode starts alone after trying configuration memory
// - absent memory leaves straps and defaults in every register
// - memory image loads only if identity codes match
// - control zero bit 7 picks alternative back-off, resets zero
// - control zero bit 3 forwards flow-control frames, else drop
// - link loss triggers one fast aging pass lasting 800 us
// - control zero bit 0 enables link-change aging, resets zero
// - control one bit 7 passes all frames only in sniffer mode
// - control one bit 5 enables pause transmit, resets one
// - control one bit 4 enables pause receive, resets one
// - control one bit 3 drops frames with mismatched short length
module sgc_bank
  import sgc_pkg::*;
#(
  parameter int FAST_AGE_CYCLES = SGC_FAST_AGE_CYC,
  parameter int ROM_WAIT        = SGC_ROM_WAIT
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire sgc_req_t    req_in,
  output logic [7:0]       rdata_out,
  input  wire logic        power_strap_high_in,
  input  wire logic        power_strap_low_in,
  output logic             rom_req_out,
  input  wire logic        rom_ack_in,
  input  wire logic        rom_present_in,
  input  wire logic [7:0]  rom_id0_in,
  input  wire logic [7:0]  rom_id1_in,
  input  wire logic [7:0]  rom_ctl0_in,
  input  wire logic [7:0]  rom_ctl1_in,
  input  wire logic [2:0]  link_up_in,
  input  wire logic        sniffer_in,
  input  wire logic        frame_fc_in,
  input  wire logic        frame_err_in,
  input  wire logic        frame_len_bad_in,
  input  wire logic [15:0] frame_type_in,
  input  wire logic        pause_tx_req_in,
  input  wire logic        pause_rx_in,
  output logic             running_out,
  output sgc_cfg_t         cfg_out,
  output logic             frame_drop_out,
  output logic             pause_tx_out,
  output logic             pause_rx_act_out,
  output logic             fast_age_out
);
  sgc_state_t  state;
  logic [7:0]  ctl0;
  logic [7:0]  ctl1;
  logic        start_bit;
  logic [1:0]  straps;
  logic        auto_mode;
  logic [7:0]  wait_cnt;
  logic        id_ok;
  logic        pass_all;

  assign straps    = {power_strap_high_in, power_strap_low_in};
  assign auto_mode = (straps == SGC_PS_AUTO);
  assign id_ok     = (rom_id0_in == SGC_FAMILY_ID) && (rom_id1_in[7:4] == SGC_CHIP_ID);

  // start-up sequencer
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state    <= SGC_ST_IDLE;
      wait_cnt <= 8'h0;
    end else begin
      case (state)
        SGC_ST_IDLE: begin
          if (auto_mode) begin
            state    <= SGC_ST_ROMRD;
            wait_cnt <= 8'(ROM_WAIT);
          end else begin
            state <= SGC_ST_HOLD;
          end
        end
        SGC_ST_ROMRD: begin
          if (rom_ack_in) begin
            state <= rom_present_in ? SGC_ST_CHECK : SGC_ST_RUN;
          end else if (wait_cnt == 8'h0) begin
            state <= SGC_ST_RUN;
          end else begin
            wait_cnt <= wait_cnt - 8'h1;
          end
        end
        SGC_ST_CHECK: begin
          state <= id_ok ? SGC_ST_LOAD : SGC_ST_RUN;
        end
        SGC_ST_LOAD: begin
          state <= SGC_ST_RUN;
        end
        SGC_ST_HOLD: begin
          if (start_bit) begin
            state <= SGC_ST_RUN;
          end
        end
        SGC_ST_RUN: begin
          if (!auto_mode && !start_bit) begin
            state <= SGC_ST_HOLD;
          end
        end
        default: begin
          state <= SGC_ST_IDLE;
        end
      endcase
    end
  end

  assign rom_req_out = (state == SGC_ST_ROMRD);
  assign running_out = (state == SGC_ST_RUN);

  // start bit, resets to one
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      start_bit <= 1'b1;
    end else if (state == SGC_ST_LOAD) begin
      start_bit <= rom_id1_in[SGC_B_START];
    end else if (req_in.wr && req_in.addr == SGC_ADDR_ID1) begin
      start_bit <= req_in.wdata[SGC_B_START];
    end
  end

  // control zero, read-only field kept at reset pattern
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ctl0 <= SGC_CTL0_RST;
    end else if (state == SGC_ST_LOAD) begin
      ctl0 <= (rom_ctl0_in & SGC_CTL0_WMASK) | (SGC_CTL0_RST & ~SGC_CTL0_WMASK);
    end else if (req_in.wr && req_in.addr == SGC_ADDR_CTL0) begin
      ctl0 <= (req_in.wdata & SGC_CTL0_WMASK) | (SGC_CTL0_RST & ~SGC_CTL0_WMASK);
    end
  end

  // control one
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ctl1 <= SGC_CTL1_RST;
    end else if (state == SGC_ST_LOAD) begin
      ctl1 <= rom_ctl1_in;
    end else if (req_in.wr && req_in.addr == SGC_ADDR_CTL1) begin
      ctl1 <= req_in.wdata;
    end
  end

  // register read port
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 8'h0;
    end else if (req_in.rd) begin
      case (req_in.addr)
        SGC_ADDR_ID0:  rdata_out <= SGC_FAMILY_ID;
        SGC_ADDR_ID1:  rdata_out <= {SGC_CHIP_ID, SGC_REV_ID, start_bit};
        SGC_ADDR_CTL0: rdata_out <= ctl0;
        SGC_ADDR_CTL1: rdata_out <= ctl1;
        default:       rdata_out <= 8'h0;
      endcase
    end
  end

  assign cfg_out.backoff_alt = ctl0[SGC_B_BACKOFF];
  assign cfg_out.pass_fc     = ctl0[SGC_B_PASSFC];
  assign cfg_out.link_age    = ctl0[SGC_B_LINKAGE];
  assign cfg_out.pass_all    = ctl1[SGC_B_PASSALL];
  assign cfg_out.tx_pause    = ctl1[SGC_B_TXFC];
  assign cfg_out.rx_pause    = ctl1[SGC_B_RXFC];
  assign cfg_out.len_check   = ctl1[SGC_B_LENCHK];

  assign pass_all = ctl1[SGC_B_PASSALL] && sniffer_in;

  // frame drop and pause decisions
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      frame_drop_out   <= 1'b0;
      pause_tx_out     <= 1'b0;
      pause_rx_act_out <= 1'b0;
    end else begin
      frame_drop_out <= !pass_all &&
                        (frame_err_in ||
                         (frame_fc_in && !ctl0[SGC_B_PASSFC]) ||
                         (ctl1[SGC_B_LENCHK] && frame_len_bad_in && frame_type_in < SGC_LEN_LIMIT));
      pause_tx_out     <= pause_tx_req_in && ctl1[SGC_B_TXFC];
      pause_rx_act_out <= pause_rx_in && ctl1[SGC_B_RXFC];
    end
  end

  sgc_fast_age #(
    .CYCLES (FAST_AGE_CYCLES)
  ) u_fast_age (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .enable_in  (ctl0[SGC_B_LINKAGE]),
    .link_in    (link_up_in),
    .busy_out   (fast_age_out)
  );

  a_hold_no_start : assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !auto_mode && !start_bit && state == SGC_ST_HOLD |=> !running_out)
    else $error("device ran without start bit");

  a_auto_start : assert property (@(posedge clk_sys_in) disable iff (rst_in)
    state == SGC_ST_ROMRD |-> ##[1:300] state != SGC_ST_ROMRD)
    else $error("auto start stuck reading memory");

  sequence s_image_ok;
    state == SGC_ST_CHECK && id_ok;
  endsequence

  sequence s_load_then_run;
    state == SGC_ST_LOAD ##1 state == SGC_ST_RUN;
  endsequence

  a_good_id_load : assert property (@(posedge clk_sys_in) disable iff (rst_in)
    s_image_ok |=> s_load_then_run)
    else $error("matching image not loaded");

  a_bad_id_noload : assert property (@(posedge clk_sys_in) disable iff (rst_in)
    state == SGC_ST_CHECK && !id_ok |=> state == SGC_ST_RUN)
    else $error("image loaded with bad identity");

  a_ro_field : assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ctl0[6:4] == SGC_CTL0_RST[6:4])
    else $error("read-only field changed");

  a_fc_drop : assert property (@(posedge clk_sys_in) disable iff (rst_in)
    frame_fc_in && !ctl0[SGC_B_PASSFC] && !pass_all |=> frame_drop_out)
    else $error("flow-control frame not dropped");

  a_pause_tx : assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !ctl1[SGC_B_TXFC] |=> !pause_tx_out)
    else $error("pause sent while disabled");

  a_pause_rx : assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !ctl1[SGC_B_RXFC] |=> !pause_rx_act_out)
    else $error("pause obeyed while disabled");

  a_len_check : assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !ctl1[SGC_B_LENCHK] && !frame_err_in && !frame_fc_in |=> !frame_drop_out)
    else $error("length drop while check off");
endmodule

/* logic/sgc_fast_age.sv */
// fast aging pass timer triggered by link loss
`timescale 1ns/10ps
module sgc_fast_age
  import sgc_pkg::*;
#(
  parameter int CYCLES = SGC_FAST_AGE_CYC
) (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  input  wire logic       enable_in,
  input  wire logic [2:0] link_in,
  output logic            busy_out
);
  logic [2:0]  link_q;
  logic [31:0] count;
  logic        link_drop;

  assign link_drop = |(link_q & ~link_in);

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      link_q <= 3'h0;
    end else begin
      link_q <= link_in;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      busy_out <= 1'b0;
      count    <= 32'h0;
    end else if (enable_in && link_drop && !busy_out) begin
      busy_out <= 1'b1;
      count    <= 32'(CYCLES);
    end else if (busy_out) begin
      if (count == 32'h0) begin
        busy_out <= 1'b0;
      end else begin
        count <= count - 32'h1;
      end
    end
  end

  a_pass_bounded : assert property (@(posedge clk_sys_in) disable iff (rst_in)
    busy_out && count == 32'h0 |=> !busy_out)
    else $error("fast aging pass did not end");
endmodule

/* verif/switch_global_control_bank_tb_top.sv */
// self-checking bench for the global control bank
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module switch_global_control_bank_tb_top;
  import sgc_pkg::*;
  logic       clk_sys_in, rst_in, ps_hi, ps_lo, rom_ack, rom_pres, snf, ffc, ferr, fbad, ptx, prx;
  logic [7:0] id0, id1, c0, c1, rdata;
  logic [2:0] link;
  logic [15:0] ftype;
  sgc_req_t   req;
  sgc_cfg_t   cfg;
  logic       rom_req, running, drop, ptx_o, prx_o, fage, rd_d;
  logic [7:0] q[$];
  logic [7:0] e;
  int         err_count, samples_checked, n, v;
  localparam int AGE_CYC = 20;
  sgc_bank #(.FAST_AGE_CYCLES(AGE_CYC), .ROM_WAIT(16)) u_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .req_in(req), .rdata_out(rdata), .power_strap_high_in(ps_hi), .power_strap_low_in(ps_lo),
    .rom_req_out(rom_req), .rom_ack_in(rom_ack), .rom_present_in(rom_pres), .rom_id0_in(id0),
    .rom_id1_in(id1), .rom_ctl0_in(c0), .rom_ctl1_in(c1), .link_up_in(link), .sniffer_in(snf),
    .frame_fc_in(ffc), .frame_err_in(ferr), .frame_len_bad_in(fbad), .frame_type_in(ftype),
    .pause_tx_req_in(ptx), .pause_rx_in(prx), .running_out(running), .cfg_out(cfg),
    .frame_drop_out(drop), .pause_tx_out(ptx_o), .pause_rx_act_out(prx_o), .fast_age_out(fage));
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  // read results checked against oldest note
  always @(posedge clk_sys_in) rd_d <= req.rd;
  always @(negedge clk_sys_in) begin
    if (rd_d === 1'b1 && q.size() > 0) begin
      e = q.pop_front();
      `CHK("rdata_out", e, rdata)
    end
  end
  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_sys_in);
    req = '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(negedge clk_sys_in);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    q.push_back(x);
    @(negedge clk_sys_in);
    req = '0;
    @(negedge clk_sys_in);
  endtask
  task automatic wait_run();
    n = 0;
    while (running !== 1'b1 && n < 200) begin
      @(negedge clk_sys_in);
      n++;
    end
    if (running !== 1'b1) begin
      err_count++;
      end_sim();
    end
  endtask
  task automatic rst(input logic [1:0] ps);
    rst_in = 1'b1;
    {ps_hi, ps_lo} = ps;
    repeat (10) @(negedge clk_sys_in);
    rst_in = 1'b0;
  endtask
  task automatic fr(input logic f, er, bd, sn, input logic [15:0] t, input logic x);
    @(negedge clk_sys_in);
    {ffc, ferr, fbad, snf, ftype} = {f, er, bd, sn, t};
    @(negedge clk_sys_in);
    `CHK("frame_drop_out", x, drop)
    {ffc, ferr, fbad, snf, ftype} = '0;
  endtask
  initial begin
    {rst_in, ps_hi, ps_lo, rom_ack, rom_pres, snf, ffc, ferr, fbad, ptx, prx} = '0;
    {id0, id1, c0, c1, ftype} = '0;
    req = '0;
    link = 3'h7;
    err_count = 0;
    samples_checked = 0;
    v = $urandom(32'ha733);
    for (int i = 0; i < 4; i++) begin
      rst(2'h0);
      rom_pres = (i == 1 || i == 2);
      id0 = (i == 2) ? SGC_FAMILY_ID : 8'h00;
      id1 = {SGC_CHIP_ID, SGC_REV_ID, 1'b1};
      c0 = 8'hc9;
      c1 = 8'h18;
      n = 0;
      while (rom_req !== 1'b1 && n < 20) begin
        @(negedge clk_sys_in);
        n++;
      end
      `CHK("rom_req_out", 1'b1, rom_req)
      if (rom_req !== 1'b1) end_sim();
      rom_ack = (i != 3);
      wait_run();
      rom_ack = 1'b0;
      rd(SGC_ADDR_CTL0, (i == 2) ? 8'hc9 : SGC_CTL0_RST);
      rd(SGC_ADDR_CTL1, (i == 2) ? 8'h18 : SGC_CTL1_RST);
      wr(SGC_ADDR_ID1, 8'h00);
      repeat (3) @(negedge clk_sys_in);
      `CHK("running_out", 1'b1, running)
      $display("test auto start %0d done", i);
    end
    for (int s = 1; s < 4; s++) begin
      rst(s[1:0]);
      wait_run();
      rd(SGC_ADDR_ID1, {SGC_CHIP_ID, SGC_REV_ID, 1'b1});
      wr(SGC_ADDR_ID1, 8'h00);
      repeat (3) @(negedge clk_sys_in);
      `CHK("running_out", 1'b0, running)
      wr(SGC_ADDR_ID1, 8'h01);
      repeat (3) @(negedge clk_sys_in);
      `CHK("running_out", 1'b1, running)
    end
    $display("test start bit done");
    rd(SGC_ADDR_ID0, SGC_FAMILY_ID);
    rd(8'h10, 8'h00);
    `CHK("backoff_alt", 1'b0, cfg.backoff_alt)
    `CHK("cfg_ctl0_rst", 2'h0, ({cfg.pass_fc, cfg.link_age}))
    wr(SGC_ADDR_CTL0, 8'hcd);
    rd(SGC_ADDR_CTL0, 8'hcd);
    `CHK("backoff_alt", 1'b1, cfg.backoff_alt)
    `CHK("cfg_ctl0", 2'h3, ({cfg.pass_fc, cfg.link_age}))
    wr(SGC_ADDR_CTL0, 8'h44);
    for (int k = 0; k < 4; k++) begin
      v = $urandom() & 8'hbf;
      wr(SGC_ADDR_CTL1, v[7:0]);
      rd(SGC_ADDR_CTL1, v[7:0]);
      `CHK("cfg_pass_len", ({v[7], v[3]}), ({cfg.pass_all, cfg.len_check}))
      `CHK("cfg_pause", v[5:4], ({cfg.tx_pause, cfg.rx_pause}))
    end
    $display("test register access done");
    for (int k = 0; k < 3; k++) begin
      wr(SGC_ADDR_CTL1, (k == 0) ? 8'h30 : ((k == 1) ? 8'h10 : 8'h20));
      @(negedge clk_sys_in);
      {ptx, prx} = 2'h3;
      @(negedge clk_sys_in);
      `CHK("pause_tx_out", (k != 1), ptx_o)
      `CHK("pause_rx_act_out", (k != 2), prx_o)
      {ptx, prx} = 2'h0;
    end
    $display("test pause done");
    wr(SGC_ADDR_CTL1, 8'h30);
    fr(1, 0, 0, 0, 16'h0000, 1);
    wr(SGC_ADDR_CTL0, 8'h4c);
    fr(1, 0, 0, 0, 16'h0000, 0);
    fr(0, 1, 0, 1, 16'h0000, 1);
    wr(SGC_ADDR_CTL1, 8'hb0);
    fr(0, 1, 0, 0, 16'h0000, 1);
    fr(0, 1, 0, 1, 16'h0000, 0);
    fr(0, 0, 1, 0, 16'h05db, 0);
    wr(SGC_ADDR_CTL1, 8'h38);
    fr(0, 0, 1, 0, 16'h05db, 1);
    fr(0, 0, 1, 0, SGC_LEN_LIMIT, 0);
    $display("test frame filter done");
    for (int en = 0; en < 2; en++) begin
      wr(SGC_ADDR_CTL0, en ? 8'h45 : 8'h44);
      @(negedge clk_sys_in);
      link = 3'h5;
      n = 0;
      for (int c = 0; c < 60; c++) begin
        @(negedge clk_sys_in);
        if (fage === 1'b1) n++;
      end
      `CHK("fast_age_cycles", (en ? AGE_CYC + 1 : 0), n)
      link = 3'h7;
    end
    $display("test fast age done");
    repeat (4) @(negedge clk_sys_in);
    end_sim();
  end
endmodule
